// [common/spsw_pkg.sv]
// Package for the serial port ownership switch: register map, fields, modes,
// escape characters and timing counts.
// Assumes a 100 MHz ref_clk and a 32-bit Avalon-MM register bus.
package spsw_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] SPSW_REG_CTRL = 4'h0;
    localparam logic [3:0] SPSW_REG_CMD = 4'h4;
    localparam logic [3:0] SPSW_REG_STATUS = 4'h8;
    localparam logic [3:0] SPSW_REG_RING = 4'hC;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int SPSW_CTRL_MODE_LSB = 0;
    localparam int SPSW_CTRL_RING_EN = 2;
    localparam int SPSW_CTRL_DCD_EN = 3;
    localparam int SPSW_CTRL_ESC_EN = 4;
    localparam int SPSW_CTRL_PPP_EN = 5;
    localparam int SPSW_CTRL_MODEM = 6;
    localparam int SPSW_CTRL_STAY = 7;
    localparam int SPSW_CTRL_RT_EN = 8;
    localparam logic [8:0] SPSW_CTRL_RESET = 9'h000;

    // ----------------------------------------
    // Command register bits (write one to act)
    // ----------------------------------------
    localparam int SPSW_CMD_BOOT = 0;
    localparam int SPSW_CMD_FORCE_UART = 1;
    localparam int SPSW_CMD_ACTIVATE = 2;
    localparam int SPSW_CMD_ALERT_ON = 3;
    localparam int SPSW_CMD_ALERT_OFF = 4;
    localparam int SPSW_CMD_REDIR_REQ = 5;
    localparam int SPSW_CMD_PPP_HIT = 6;
    localparam int SPSW_CMD_RELEASE = 7;

    // ----------------------------------------
    // Status register fields
    // ----------------------------------------
    localparam int SPSW_STAT_OWNER = 0;
    localparam int SPSW_STAT_BOOTED = 1;
    localparam int SPSW_STAT_ALERT = 2;
    localparam int SPSW_STAT_DENIED = 3;
    localparam int SPSW_STAT_INIT_MODEM = 4;
    localparam int SPSW_STAT_WATCH = 5;
    localparam int SPSW_STAT_LSB_MODE = 8;

    // ----------------------------------------
    // Access modes and escape detector states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SPSW_MODE_DISABLED = 2'b00,
        SPSW_MODE_PREBOOT = 2'b01,
        SPSW_MODE_ALWAYS = 2'b10,
        SPSW_MODE_SHARED = 2'b11
    } spsw_mode_e;

    typedef enum logic [1:0] {
        SPSW_ESC_IDLE = 2'b00,
        SPSW_ESC_SEEN = 2'b01
    } spsw_esc_e;

    localparam logic [7:0] SPSW_CH_ESC = 8'h1B;
    localparam logic [7:0] SPSW_CH_OPEN = 8'h28;
    localparam logic [7:0] SPSW_CH_Q = 8'h51;

    // ----------------------------------------
    // Timing: ring interval unit and default
    // ----------------------------------------
    localparam int SPSW_CLK_MHZ = 100;
    localparam int SPSW_RING_UNIT_US = 1000;
    localparam int SPSW_RING_UNIT_CYC = SPSW_RING_UNIT_US * SPSW_CLK_MHZ;
    localparam logic [15:0] SPSW_RING_RESET = 16'h0BB8;

    // Serial lines as one carrier
    typedef struct packed {
        logic txd;
        logic rxd;
    } spsw_serial_s;

endpackage : spsw_pkg

// [src/spsw_switch.sv]
// Serial connector ownership switch: routes TxD/RxD to the management
// controller or the baseboard UART.
// Assumes synchronous inputs on ref_clk, power/reset flags from board logic,
// and a received byte stream with a one-cycle valid strobe.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps

module spsw_switch
    import spsw_pkg::*;
#(
    parameter int RING_UNIT_CYC = SPSW_RING_UNIT_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic power_on,
    input wire logic hard_reset,
    input wire logic ring_indicate_line,
    input wire logic carrier_detect_line,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic callback_done,
    input wire spsw_serial_s conn,
    input wire spsw_serial_s mgmt,
    input wire spsw_serial_s uart,
    output spsw_serial_s conn_out,
    output spsw_serial_s mgmt_out,
    output spsw_serial_s uart_out,
    output logic mgmt_owns,
    output logic modem_init_req,
    output logic session_watch,
    output logic ping_req
);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (RING_UNIT_CYC < 1)
    begin : g_bad_unit
        $error("RING_UNIT_CYC must be at least one");
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [8:0] ctrl_ff;
    logic [15:0] ring_time_ff;
    logic ack_ff;
    logic wr_hit;
    logic [7:0] cmd;
    spsw_mode_e mode;

    // One wait state per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wr_hit = avs_write & ack_ff;
    assign cmd = (wr_hit && avs_address == SPSW_REG_CMD) ? avs_writedata[7:0] : 8'h00;
    assign mode = spsw_mode_e'(ctrl_ff[SPSW_CTRL_MODE_LSB +: 2]);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
        end
    end

    // Mode lives here; the non-volatile copy is loaded by firmware after power loss
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_ff <= SPSW_CTRL_RESET;
            ring_time_ff <= SPSW_RING_RESET;
        end
        else if (wr_hit && avs_address == SPSW_REG_CTRL)
        begin
            ctrl_ff <= avs_writedata[8:0];
        end
        else if (wr_hit && avs_address == SPSW_REG_RING)
        begin
            ring_time_ff <= avs_writedata[15:0];
        end
    end

    // ----------------------------------------
    // Host state: booted flag and alert hold
    // ----------------------------------------
    logic booted_ff;
    logic alert_ff;
    logic denied_ff;
    logic power_on_ff;
    logic power_up_edge;

    assign power_up_edge = power_on & ~power_on_ff;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            booted_ff <= 1'b0;
            power_on_ff <= 1'b1;
        end
        else
        begin
            power_on_ff <= power_on;
            if (!power_on || hard_reset)
            begin
                booted_ff <= 1'b0;
            end
            else if (cmd[SPSW_CMD_BOOT])
            begin
                booted_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            alert_ff <= 1'b0;
        end
        else if (cmd[SPSW_CMD_ALERT_ON])
        begin
            alert_ff <= 1'b1;
        end
        else if (cmd[SPSW_CMD_ALERT_OFF])
        begin
            alert_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Ring timer and carrier loss detect
    // ----------------------------------------
    logic [31:0] unit_cnt_ff;
    logic [15:0] ring_cnt_ff;
    logic ring_done;
    logic dcd_ff;
    logic dcd_loss;

    // Ringing that stops before the interval expires leaves the call alone
    always_ff @(posedge ref_clk)
    begin
        if (rst || !ring_indicate_line)
        begin
            unit_cnt_ff <= 32'h0000_0000;
            ring_cnt_ff <= 16'h0000;
        end
        else if (!ring_done)
        begin
            if (unit_cnt_ff == 32'(RING_UNIT_CYC - 1))
            begin
                unit_cnt_ff <= 32'h0000_0000;
                ring_cnt_ff <= ring_cnt_ff + 16'h0001;
            end
            else
            begin
                unit_cnt_ff <= unit_cnt_ff + 32'h0000_0001;
            end
        end
    end

    assign ring_done = ring_indicate_line && (ring_cnt_ff >= ring_time_ff);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dcd_ff <= 1'b0;
        end
        else
        begin
            dcd_ff <= carrier_detect_line;
        end
    end

    assign dcd_loss = dcd_ff & ~carrier_detect_line;

    // ----------------------------------------
    // Escape sequence detector
    // ----------------------------------------
    spsw_esc_e esc_ff;
    logic esc_open;
    logic esc_quit;

    always_ff @(posedge ref_clk)
    begin
        if (rst || !ctrl_ff[SPSW_CTRL_ESC_EN])
        begin
            esc_ff <= SPSW_ESC_IDLE;
        end
        else if (rx_valid)
        begin
            esc_ff <= (rx_byte == SPSW_CH_ESC) ? SPSW_ESC_SEEN : SPSW_ESC_IDLE;
        end
    end

    assign esc_open = rx_valid && esc_ff == SPSW_ESC_SEEN && rx_byte == SPSW_CH_OPEN;
    assign esc_quit = rx_valid && esc_ff == SPSW_ESC_SEEN && rx_byte == SPSW_CH_Q;

    // ----------------------------------------
    // Ownership decision
    // ----------------------------------------
    logic owner_ff;
    logic nxt_owner;
    logic enabled;
    logic auto_ok;
    logic event_ok;
    logic claim;
    logic release_now;

    assign enabled = mode != SPSW_MODE_DISABLED;

    // Pre-boot mode stays hands off at runtime unless software re-enables
    always_comb
    begin
        unique case (mode)
            SPSW_MODE_DISABLED: auto_ok = ctrl_ff[SPSW_CTRL_RT_EN];
            SPSW_MODE_PREBOOT: auto_ok = !booted_ff || ctrl_ff[SPSW_CTRL_RT_EN];
            SPSW_MODE_ALWAYS: auto_ok = 1'b1;
            SPSW_MODE_SHARED: auto_ok = 1'b1;
        endcase
    end

    always_comb
    begin
        event_ok = 1'b0;
        if (auto_ok)
        begin
            event_ok = (ring_done && ctrl_ff[SPSW_CTRL_RING_EN])
                || (dcd_loss && ctrl_ff[SPSW_CTRL_DCD_EN]);
        end
    end

    assign claim = (enabled && (!power_on || power_up_edge || hard_reset))
        || event_ok
        || cmd[SPSW_CMD_ACTIVATE]
        || (ctrl_ff[SPSW_CTRL_PPP_EN] && cmd[SPSW_CMD_PPP_HIT] && !owner_ff)
        || (esc_open && !owner_ff);

    assign release_now = cmd[SPSW_CMD_FORCE_UART]
        || (cmd[SPSW_CMD_BOOT] && mode == SPSW_MODE_PREBOOT)
        || cmd[SPSW_CMD_RELEASE]
        || (esc_quit && owner_ff)
        || (cmd[SPSW_CMD_REDIR_REQ] && !ctrl_ff[SPSW_CTRL_STAY]);

    // Firmware force wins; otherwise a claim beats a release in the same cycle
    always_comb
    begin
        nxt_owner = owner_ff;
        if (cmd[SPSW_CMD_FORCE_UART])
        begin
            nxt_owner = 1'b0;
        end
        else if (claim)
        begin
            nxt_owner = 1'b1;
        end
        else if (release_now)
        begin
            nxt_owner = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            owner_ff <= 1'b0;
        end
        else
        begin
            owner_ff <= nxt_owner;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            denied_ff <= 1'b0;
        end
        else if (cmd[SPSW_CMD_REDIR_REQ] || cmd[SPSW_CMD_ACTIVATE])
        begin
            denied_ff <= cmd[SPSW_CMD_REDIR_REQ] && ctrl_ff[SPSW_CTRL_STAY];
        end
    end

    // ----------------------------------------
    // Answer handling after a claim
    // ----------------------------------------
    logic claim_edge;

    assign claim_edge = nxt_owner & ~owner_ff;

    always_ff @(posedge ref_clk)
    begin
        if (rst || !nxt_owner)
        begin
            modem_init_req <= 1'b0;
            session_watch <= 1'b0;
        end
        else if (claim_edge)
        begin
            session_watch <= carrier_detect_line;
            modem_init_req <= !carrier_detect_line && ctrl_ff[SPSW_CTRL_MODEM];
        end
        else if (carrier_detect_line)
        begin
            modem_init_req <= 1'b0;
            session_watch <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ping_req <= 1'b0;
        end
        else
        begin
            ping_req <= callback_done && (owner_ff || alert_ff);
        end
    end

    // ----------------------------------------
    // Routing mux: alert seizes without changing the decided owner
    // ----------------------------------------
    logic route_mgmt;

    assign route_mgmt = owner_ff | alert_ff;
    assign mgmt_owns = route_mgmt;

    always_comb
    begin
        conn_out.txd = route_mgmt ? mgmt.txd : uart.txd;
        conn_out.rxd = 1'b1;
        mgmt_out.txd = 1'b1;
        mgmt_out.rxd = route_mgmt ? conn.rxd : 1'b1;
        uart_out.txd = 1'b1;
        uart_out.rxd = route_mgmt ? 1'b1 : conn.rxd;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && !ack_ff)
        begin
            avs_readdata <= 32'h0000_0000;
            unique case (avs_address)
                SPSW_REG_CTRL: avs_readdata[8:0] <= ctrl_ff;
                SPSW_REG_RING: avs_readdata[15:0] <= ring_time_ff;
                SPSW_REG_STATUS: avs_readdata[9:0] <= {mode, 2'b00, session_watch,
                    modem_init_req, denied_ff, alert_ff, booted_ff, owner_ff};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : spsw_switch

// [verification/serial_port_ownership_switch_test.sv]
// Self-checking bench for the ownership switch with a far-end model.
// Assumes one wait state on the bus and a shortened ring unit.
`timescale 1ns/1ps
`define CK(n, e, a) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module serial_port_ownership_switch_test
    import spsw_pkg::*;
;
    localparam int RU = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] rd_v;
    logic avs_waitrequest;
    logic power_on = 1'b1;
    logic hard_reset = 1'b0;
    logic callback_done = 1'b0;
    logic ring_indicate_line, carrier_detect_line, rx_valid, mgmt_owns;
    logic modem_init_req, session_watch, ping_req;
    logic [7:0] rx_byte;
    spsw_serial_s conn, conn_out, mgmt_out, uart_out;
    spsw_serial_s mgmt;
    spsw_serial_s uart;
    logic [31:0] seed = 32'h86679166;
    int failures = 0;
    int n_tests = 0;

    always #5 ref_clk = ~ref_clk;

    spsw_switch #(.RING_UNIT_CYC(RU)) dut (.ref_clk(ref_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .power_on(power_on), .hard_reset(hard_reset),
        .ring_indicate_line(ring_indicate_line), .carrier_detect_line(carrier_detect_line),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .callback_done(callback_done),
        .conn(conn), .mgmt(mgmt), .uart(uart), .conn_out(conn_out), .mgmt_out(mgmt_out),
        .uart_out(uart_out), .mgmt_owns(mgmt_owns), .modem_init_req(modem_init_req),
        .session_watch(session_watch), .ping_req(ping_req));

    spsw_far_end far (.ref_clk(ref_clk), .ring_indicate_line(ring_indicate_line),
        .carrier_detect_line(carrier_detect_line), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .conn(conn));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Fresh from reset, so pre-boot still counts as before boot
    function logic claim_exp(input int m);
        return m != 0;
    endfunction : claim_exp

    always @(posedge ref_clk)
    begin
        mgmt <= 2'(xs());
        uart <= 2'(xs());
    end

    task wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task rd(input logic [3:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : rd

    task cmd(input int b);
        wr(SPSW_REG_CMD, 32'h1 << b);
    endtask : cmd

    task own(input logic e);
        repeat (3) @(posedge ref_clk);
        #1 `CK("owner", e, mgmt_owns)
        @(posedge ref_clk);
    endtask : own

    task esc(input logic [7:0] c);
        far.sb(SPSW_CH_ESC);
        far.sb(c);
    endtask : esc

    // One-cycle pulse: 0 reset, 1 hard reset, otherwise callback done
    task pulse(input int w);
        case (w)
            0: rst <= 1'b1;
            1: hard_reset <= 1'b1;
            default: callback_done <= 1'b1;
        endcase
        @(posedge ref_clk);
        rst <= 1'b0;
        hard_reset <= 1'b0;
        callback_done <= 1'b0;
    endtask : pulse

    task complete_run();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        logic [7:0] b;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(SPSW_REG_RING, rd_v);
        `CK("ring", 32'h0BB8, rd_v)
        rd(4'h2, rd_v);
        `CK("unmapped", 32'h0, rd_v)
        esc(SPSW_CH_OPEN);
        own(1'b0);
        wr(SPSW_REG_CTRL, 32'h13);
        repeat (8)
        begin
            b = 8'(xs());
            if (b == SPSW_CH_ESC)
                b = 8'h00;
            far.sb(b);
        end
        own(1'b0);
        esc(SPSW_CH_OPEN);
        own(1'b1);
        esc(SPSW_CH_Q);
        own(1'b0);
        esc(SPSW_CH_OPEN);
        cmd(SPSW_CMD_FORCE_UART);
        own(1'b0);
        cmd(SPSW_CMD_ALERT_ON);
        own(1'b1);
        cmd(SPSW_CMD_ALERT_OFF);
        own(1'b0);
        $display("test escapes, force and alert done");
        wr(SPSW_REG_CTRL, 32'h82);
        cmd(SPSW_CMD_ACTIVATE);
        cmd(SPSW_CMD_BOOT);
        own(1'b1);
        cmd(SPSW_CMD_REDIR_REQ);
        own(1'b1);
        rd(SPSW_REG_STATUS, rd_v);
        `CK("denied", 1'b1, rd_v[SPSW_STAT_DENIED])
        wr(SPSW_REG_CTRL, 32'h02);
        cmd(SPSW_CMD_REDIR_REQ);
        own(1'b0);
        cmd(SPSW_CMD_PPP_HIT);
        own(1'b0);
        wr(SPSW_REG_CTRL, 32'h22);
        cmd(SPSW_CMD_PPP_HIT);
        own(1'b1);
        pulse(2);
        #1 `CK("ping", 1'b1, ping_req)
        @(posedge ref_clk);
        cmd(SPSW_CMD_RELEASE);
        own(1'b0);
        $display("test redirection, snoop and ping done");
        wr(SPSW_REG_CTRL, 32'h05);
        wr(SPSW_REG_RING, 32'h1);
        pulse(1);
        own(1'b1);
        rd(SPSW_REG_CTRL, rd_v);
        `CK("ctrl", 32'h05, rd_v)
        cmd(SPSW_CMD_BOOT);
        own(1'b0);
        far.ring(12);
        own(1'b0);
        cmd(SPSW_CMD_ACTIVATE);
        own(1'b1);
        cmd(SPSW_CMD_BOOT);
        power_on <= 1'b0;
        own(1'b1);
        power_on <= 1'b1;
        own(1'b1);
        wr(SPSW_REG_CTRL, 32'h0);
        cmd(SPSW_CMD_FORCE_UART);
        pulse(1);
        own(1'b0);
        power_on <= 1'b0;
        own(1'b0);
        power_on <= 1'b1;
        wr(SPSW_REG_CTRL, 32'h104);
        far.ring(12);
        own(1'b1);
        cmd(SPSW_CMD_FORCE_UART);
        $display("test power and reset claims done");
        wr(SPSW_REG_CTRL, 32'h46);
        wr(SPSW_REG_RING, 32'h3);
        far.ring(8);
        own(1'b0);
        far.ring(20);
        own(1'b1);
        `CK("modem init", 1'b1, modem_init_req)
        cmd(SPSW_CMD_FORCE_UART);
        far.cd(1'b1);
        own(1'b0);
        `CK("modem init", 1'b0, modem_init_req)
        far.ring(20);
        own(1'b1);
        `CK("watch", 1'b1, session_watch)
        $display("test ring answer done");
        for (int m = 0; m < 4; m++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                pulse(0);
                far.cd(s[0]);
                wr(SPSW_REG_RING, 32'h1);
                wr(SPSW_REG_CTRL, 32'(m) | (s ? 32'h8 : 32'h4));
                if (s)
                    far.cd(1'b0);
                else
                    far.ring(10);
                own(claim_exp(m));
            end
        end
        $display("test mode table done");
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        complete_run();
    end
endmodule : serial_port_ownership_switch_test

bind spsw_switch spsw_switch_chk chk (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .power_on(power_on), .hard_reset(hard_reset), .callback_done(callback_done),
    .conn(conn), .mgmt(mgmt), .uart(uart), .conn_out(conn_out), .mgmt_out(mgmt_out),
    .uart_out(uart_out), .mgmt_owns(mgmt_owns), .ping_req(ping_req));

// [verification/spsw_far_end.sv]
// Far end model: remote console or modem on the shared connector.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
module spsw_far_end
    import spsw_pkg::*;
(
    input wire logic ref_clk,
    output logic ring_indicate_line,
    output logic carrier_detect_line,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output spsw_serial_s conn
);
    initial
    begin
        ring_indicate_line = 1'b0;
        carrier_detect_line = 1'b0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        conn = 2'b01;
    end

    // Line content changes every cycle so a stale route shows up
    always @(posedge ref_clk)
        conn <= ~conn;

    // Caller may hang up before the ring interval runs out
    task ring(input int n);
        ring_indicate_line <= 1'b1;
        repeat (n) @(posedge ref_clk);
        ring_indicate_line <= 1'b0;
        @(posedge ref_clk);
    endtask : ring

    task sb(input logic [7:0] b);
        rx_byte <= b;
        rx_valid <= 1'b1;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
        @(posedge ref_clk);
    endtask : sb

    task cd(input logic v);
        carrier_detect_line <= v;
        @(posedge ref_clk);
    endtask : cd
endmodule : spsw_far_end

// [verification/spsw_switch_props.sv]
// Checker for the ownership switch, bound to the top module's ports.
// Assumes bus masters hold a request until waitrequest drops.
`timescale 1ns/1ps
module spsw_switch_chk
    import spsw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic power_on,
    input wire logic hard_reset,
    input wire logic callback_done,
    input wire spsw_serial_s conn,
    input wire spsw_serial_s mgmt,
    input wire spsw_serial_s uart,
    input wire spsw_serial_s conn_out,
    input wire spsw_serial_s mgmt_out,
    input wire spsw_serial_s uart_out,
    input wire logic mgmt_owns,
    input wire logic ping_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Mode shadow, from completed control writes
    // ----------------------------------------
    logic [1:0] mode_ff;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            mode_ff <= 2'h0;
        else if (avs_write && !avs_waitrequest && avs_address == SPSW_REG_CTRL)
            mode_ff <= avs_writedata[1:0];
    end

    sequence req_s;
        $rose(avs_read || avs_write);
    endsequence
    sequence cb_owned_s;
        callback_done && mgmt_owns;
    endsequence
    sequence claim_ev_s;
        mode_ff != SPSW_MODE_DISABLED && (hard_reset || !power_on);
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    bus_wait_a: assert property (req_s |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Bus answer without one wait cycle");
    tx_mux_a: assert property (conn_out.txd == (mgmt_owns ? mgmt.txd : uart.txd))
        else $error("Connector transmit from wrong owner");
    rx_mgmt_a: assert property (mgmt_owns |-> mgmt_out.rxd == conn.rxd && uart_out.rxd)
        else $error("Receive line reaches the UART while controller owns");
    rx_uart_a: assert property (!mgmt_owns |-> uart_out.rxd == conn.rxd && mgmt_out.rxd)
        else $error("Receive line reaches the controller while UART owns");
    claim_on_a: assert property (claim_ev_s |=> mgmt_owns)
        else $error("No claim at power down or hard reset");
    disabled_keep_a: assert property (mode_ff == SPSW_MODE_DISABLED && !mgmt_owns
        && (hard_reset || !power_on) |=> !mgmt_owns)
        else $error("Claim in disabled mode");
    ping_cause_a: assert property (ping_req |-> $past(callback_done))
        else $error("Ping without callback");
    ping_go_a: assert property (cb_owned_s |=> ping_req ##1 !ping_req)
        else $error("Callback gave no single ping pulse");
endmodule : spsw_switch_chk
